// File: design/sradc_conversion_readout.sv
// Conversion sequencing, calibration and serial readout of a SAR converter.
// Assumes an analog comparator on core_clk and a host SPI master owning serialClk.
//
// How it works
// [R1] Self-calibrate after reset before converting.
// [R2] Recalibrate request restarts calibration anytime.
// [R3] After calibration, enter tracking standby.
// [R4] Strobe rising edge starts a conversion.
// [R5] Host holds strobe high until done.
// [R6] Strobe low after done presents result.
// [R7] Return to standby, track next sample.
// [R8] Host clocks data only during standby.
// [R9] Conversion timed by core clock only.
// [R10] Result read belongs to latest conversion.
// [R11] Word width is 16, 14 or 12.
// [R12] Cycle fits one or half Msps.
// [R13] Host serial clock at most 100 MHz.
// [R14] Three wires: strobe, clock, data out.
// [R15] Result shifted MSB first, one per clock.
// [R16] No conversions or results during calibration.
`timescale 1ns/1ps
module sradc_conversion_readout
   import sradc_pkg::*;
#(
   parameter int RES_BITS = RES_BITS_DFLT, // [R11]
   parameter int CAL_CYCLES = CAL_CYCLES_DFLT,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DFLT
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic conversion_start_strobe,
   input wire logic recalRequest,
   input wire logic serialClk,
   output logic serial_result_out,
   input wire logic compareHigh,
   output logic [RES_BITS-1:0] dacCode,
   output logic trackEnable,
   output logic calActive,
   output logic convBusy,
   output logic resultValid
);
   localparam int BW = $clog2(RES_BITS + 1);
   localparam int CW = $clog2(CAL_CYCLES + 1);

   sradc_state_e state_q;
   logic strobeMeta_q, strobeSync_q, strobeDly_q;
   logic recalMeta_q, recalSync_q, recalDly_q;
   logic strobeRise, recalEdge;
   logic [CW-1:0] calCnt_q;
   logic [BW-1:0] bitIdx_q;
   logic [RES_BITS-1:0] sar_q;
   logic [RES_BITS-1:0] hold_q;
   logic resultValid_q;
   logic [SER_CNT_BITS-1:0] base_q;
   logic fifoInReady, fifoOutValid, fifoPush, fifoPop;
   logic [RES_BITS-1:0] fifoOutData, sarFinal, trialBit;
   logic lastStep;
   logic [SER_CNT_BITS-1:0] grayMeta_q, graySync_q, serBinInCore;
   // Link side
   logic rstSerMeta_q, rstSer_q;
   logic [SER_CNT_BITS-1:0] serCnt_q, serGray_q, serOffset;

   // Pins from the host are foreign to core_clk
   always_ff @(posedge core_clk) begin
      if (reset) begin
         strobeMeta_q <= SYNC_RESET_VAL;
         strobeSync_q <= SYNC_RESET_VAL;
         strobeDly_q <= SYNC_RESET_VAL;
         recalMeta_q <= SYNC_RESET_VAL;
         recalSync_q <= SYNC_RESET_VAL;
         recalDly_q <= SYNC_RESET_VAL;
      end else begin
         strobeMeta_q <= conversion_start_strobe;
         strobeSync_q <= strobeMeta_q;
         strobeDly_q <= strobeSync_q;
         recalMeta_q <= recalRequest;
         recalSync_q <= recalMeta_q;
         recalDly_q <= recalSync_q;
      end
   end

   assign strobeRise = strobeSync_q && !strobeDly_q;
   assign recalEdge = recalSync_q && !recalDly_q;
   assign lastStep = (bitIdx_q == BW'(RES_BITS - 1));
   assign trialBit = {1'b1, {(RES_BITS-1){1'b0}}} >> bitIdx_q;
   // Comparator verdict on the bit under trial decides whether it stays
   assign sarFinal = compareHigh ? (sar_q & ~trialBit) : sar_q;

   // Sequencer; a recalibration request overrides any state
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= SRADC_CAL; // [R1]
      end else if (recalEdge) begin
         state_q <= SRADC_CAL; // [R2]
      end else begin
         case (state_q)
            SRADC_CAL: begin
               if (calCnt_q == CW'(CAL_CYCLES - 1)) begin
                  state_q <= SRADC_STANDBY; // [R3]
               end
            end
            SRADC_STANDBY: begin
               // A full FIFO stalls new conversions rather than dropping a word
               if (strobeRise && fifoInReady) begin
                  state_q <= SRADC_CONVERT; // [R4]
               end
            end
            SRADC_CONVERT: begin
               if (lastStep) begin
                  state_q <= SRADC_WAITLOW; // [R9] [R12]
               end
            end
            SRADC_WAITLOW: begin
               if (!strobeSync_q) begin
                  state_q <= SRADC_STANDBY; // [R5] [R7]
               end
            end
            default: state_q <= SRADC_CAL;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || recalEdge || state_q != SRADC_CAL) begin
         calCnt_q <= '0;
      end else begin
         calCnt_q <= calCnt_q + CW'(1);
      end
   end

   // Successive approximation, one bit per oscillator cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         bitIdx_q <= '0;
         sar_q <= '0;
      end else if (state_q == SRADC_STANDBY && strobeRise && fifoInReady && !recalEdge) begin
         bitIdx_q <= '0;
         sar_q <= {1'b1, {(RES_BITS-1){1'b0}}};
      end else if (state_q == SRADC_CONVERT) begin
         bitIdx_q <= bitIdx_q + BW'(1);
         sar_q <= sarFinal | (trialBit >> 1); // [R9]
      end
   end

   assign fifoPush = (state_q == SRADC_CONVERT) && lastStep && !recalEdge; // [R10]
   assign fifoPop = (state_q == SRADC_WAITLOW) && !strobeSync_q && !recalEdge;

   sradc_fifo #(
      .WIDTH(RES_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(core_clk),
      .reset(reset || (state_q == SRADC_CAL)),
      .inValid(fifoPush),
      .inReady(fifoInReady),
      .inData(sarFinal),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData(fifoOutData)
   );

   // Link counter position, gray coded, brought into core_clk
   always_ff @(posedge core_clk) begin
      if (reset) begin
         grayMeta_q <= '0;
         graySync_q <= '0;
      end else begin
         grayMeta_q <= serGray_q;
         graySync_q <= grayMeta_q;
      end
   end

   always_comb begin
      serBinInCore[SER_CNT_BITS-1] = graySync_q[SER_CNT_BITS-1];
      for (int i = SER_CNT_BITS - 2; i >= 0; i--) begin
         serBinInCore[i] = serBinInCore[i+1] ^ graySync_q[i];
      end
   end

   // Hold word and start position only change while the link clock is idle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         hold_q <= '0;
         base_q <= '0;
         resultValid_q <= 1'b0;
      end else if (recalEdge || state_q == SRADC_CAL) begin
         resultValid_q <= 1'b0; // [R16]
      end else if (fifoPop && fifoOutValid) begin
         hold_q <= fifoOutData; // [R6] [R10]
         base_q <= serBinInCore; // [R8]
         resultValid_q <= 1'b1;
      end
   end

   assign dacCode = sar_q;
   assign trackEnable = (state_q == SRADC_STANDBY);
   assign calActive = (state_q == SRADC_CAL);
   assign convBusy = (state_q == SRADC_CONVERT);
   assign resultValid = resultValid_q;

   // Link domain: the host clock may stop between frames, so the bit position
   // is a free-running count taken relative to the base caught at load time.
   always_ff @(posedge serialClk) begin
      rstSerMeta_q <= reset;
      rstSer_q <= rstSerMeta_q;
   end

   always_ff @(posedge serialClk) begin
      if (rstSer_q) begin
         serCnt_q <= '0;
         serGray_q <= '0;
      end else begin
         serCnt_q <= serCnt_q + SER_CNT_BITS'(1); // [R13]
         serGray_q <= (serCnt_q + SER_CNT_BITS'(1)) ^ ((serCnt_q + SER_CNT_BITS'(1)) >> 1);
      end
   end

   assign serOffset = serCnt_q - base_q;
   // Bit select from held flops; zeros once the word is exhausted
   assign serial_result_out = (resultValid_q && serOffset < SER_CNT_BITS'(RES_BITS)) ?
      hold_q[RES_BITS - 1 - int'(serOffset)] : 1'b0; // [R14] [R15]

   // Checks on core_clk, except the MSB-first check on serialClk
   sequence s_conv_done;
      state_q == SRADC_CONVERT && lastStep && !recalEdge;
   endsequence

   sequence s_host_lowered;
      state_q == SRADC_WAITLOW && !strobeSync_q && !recalEdge;
   endsequence

   sequence s_strobe_held;
      state_q == SRADC_WAITLOW && strobeSync_q && !recalEdge;
   endsequence

   logic [RES_BITS-1:0] lastPushed_q;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         lastPushed_q <= '0;
      end else if (fifoPush) begin
         lastPushed_q <= sarFinal;
      end
   end

   a_cal_after_reset: assert property (@(posedge core_clk) // [R1]
      $fell(reset) |-> calActive && !resultValid && calCnt_q == '0)
      else $error("calibration not entered after reset");

   a_recal_restart: assert property (@(posedge core_clk) disable iff (reset) // [R2]
      recalEdge |=> calActive && calCnt_q == '0 ##1 calActive)
      else $error("recalibration did not restart");

   a_cal_to_standby: assert property (@(posedge core_clk) disable iff (reset) // [R3]
      (calActive && calCnt_q == CW'(CAL_CYCLES - 1) && !recalEdge) |=> trackEnable)
      else $error("standby not entered after calibration");

   a_strobe_starts: assert property (@(posedge core_clk) disable iff (reset) // [R4]
      (trackEnable && strobeRise && fifoInReady && !recalEdge) |=> convBusy && bitIdx_q == '0)
      else $error("conversion did not start on strobe rise");

   a_conv_length: assert property (@(posedge core_clk) disable iff (reset) // [R9]
      $rose(convBusy) |-> ##(RES_BITS - 1) ((convBusy && lastStep) || calActive))
      else $error("conversion length wrong");

   a_result_on_low: assert property (@(posedge core_clk) disable iff (reset) // [R6] [R7]
      s_host_lowered |=> resultValid && trackEnable)
      else $error("result not presented after strobe low");

   a_same_sample: assert property (@(posedge core_clk) disable iff (reset) // [R10]
      s_host_lowered |=> hold_q == lastPushed_q)
      else $error("held result is not the latest conversion");

   a_cal_no_result: assert property (@(posedge core_clk) disable iff (reset) // [R16]
      calActive |-> !resultValid && !fifoPush && !convBusy)
      else $error("activity during calibration");

   a_msb_first: assert property (@(posedge serialClk) disable iff (rstSer_q) // [R15]
      (resultValid_q && serOffset == '0) |-> serial_result_out == hold_q[RES_BITS-1])
      else $error("first serial bit is not the MSB");

   a_hold_until_low: assert property (@(posedge core_clk) disable iff (reset) // [R6]
      s_strobe_held |=> state_q == SRADC_WAITLOW && !trackEnable)
      else $error("result presented while strobe still high");

   a_push_single: assert property (@(posedge core_clk) disable iff (reset) // [R10]
      s_conv_done |=> !fifoPush && state_q == SRADC_WAITLOW)
      else $error("conversion pushed more than one word");

   a_first_trial: assert property (@(posedge core_clk) disable iff (reset) // [R11]
      $rose(convBusy) |-> dacCode == {1'b1, {(RES_BITS-1){1'b0}}})
      else $error("conversion did not start with the top trial bit");

   a_start_in_standby: assert property (@(posedge core_clk) disable iff (reset) // [R4]
      $rose(convBusy) |-> $past(trackEnable))
      else $error("conversion started outside standby");

   a_result_held: assert property (@(posedge core_clk) disable iff (reset) // [R10]
      (resultValid && !fifoPop) |=> $stable(hold_q))
      else $error("held result changed during readout");

   a_recal_clears: assert property (@(posedge core_clk) disable iff (reset) // [R16]
      recalEdge |=> !resultValid && !convBusy)
      else $error("recalibration left a result or conversion active");
endmodule

// File: design/sradc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sradc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr_q;
   logic [PW-1:0] rdPtr_q;
   logic [PW:0] count_q;
   logic push;
   logic pop;

   assign inReady = (count_q != PW'(0) + (PW+1)'(DEPTH));
   assign outValid = (count_q != '0);
   assign push = inValid && inReady;
   assign pop = outValid && outReady;
   assign outData = mem[rdPtr_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (push) begin
            wrPtr_q <= (wrPtr_q == PW'(DEPTH - 1)) ? '0 : wrPtr_q + PW'(1);
         end
         if (pop) begin
            rdPtr_q <= (rdPtr_q == PW'(DEPTH - 1)) ? '0 : rdPtr_q + PW'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         count_q <= '0;
      end else if (push && !pop) begin
         count_q <= count_q + (PW+1)'(1);
      end else if (pop && !push) begin
         count_q <= count_q - (PW+1)'(1);
      end
   end
endmodule

// File: design/sradc_pkg.sv
// Shared constants for the converter control block.
// Assumes a 200 MHz core clock standing in for the on-chip conversion oscillator.
package sradc_pkg;
   localparam int RES_BITS_DFLT = 16;
   localparam int FIFO_DEPTH_DFLT = 4;
   localparam int CAL_CYCLES_DFLT = 1024;
   localparam int CORE_PERIOD_PS = 5000;
   // Fastest throughput grade: one sample per 1000 ns
   localparam int SAMPLE_PERIOD_NS = 1000;
   localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS * 1000) / CORE_PERIOD_PS;
   localparam int SER_CNT_BITS = 5;
   localparam logic SYNC_RESET_VAL = 1'b0;

   typedef enum logic [3:0] {
      SRADC_CAL = 4'h1,
      SRADC_STANDBY = 4'h2,
      SRADC_CONVERT = 4'h4,
      SRADC_WAITLOW = 4'h8
   } sradc_state_e;
endpackage

// File: test/sar_adc_conversion_readout_bench.sv
// Self-checking bench for the converter control block and its FIFO.
// Assumes an ideal comparator that reports the DAC above a held input code.
`timescale 1ns/1ps
module sar_adc_conversion_readout_bench;
   localparam int RB = 16;
   localparam int CAL = 16;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic recalRequest = 1'b0;
   logic compareHigh = 1'b0;
   logic strobe, serialClk, resultBit, trackEnable, calActive, convBusy, resultValid;
   logic [RB-1:0] dacCode;
   logic [RB-1:0] analogIn = '0;
   int mismatches = 0;
   int cmpCount = 0;
   int busyCycles = 0;
   always #2.5 core_clk = ~core_clk;
   always @(negedge core_clk)
      compareHigh <= (dacCode > analogIn);
   always @(posedge core_clk)
      if (convBusy === 1'b1)
         busyCycles++;
   sradc_conversion_readout #(.RES_BITS(RB), .CAL_CYCLES(CAL)) uut (
      .core_clk(core_clk), .reset(reset), .conversion_start_strobe(strobe),
      .recalRequest(recalRequest), .serialClk(serialClk), .serial_result_out(resultBit),
      .compareHigh(compareHigh), .dacCode(dacCode), .trackEnable(trackEnable),
      .calActive(calActive), .convBusy(convBusy), .resultValid(resultValid));
   sradc_host_model #(.RES_BITS(RB)) host (
      .core_clk(core_clk), .strobe(strobe), .serialClk(serialClk), .resultBit(resultBit));
   task automatic print_verdict;
      $display("mismatches %0d comparisons %0d", mismatches, cmpCount);
      if (mismatches == 0 && cmpCount > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Counts edges until calActive or trackEnable is high
   task automatic waitSig(input bit cal, input int bound, output int n);
      n = 0;
      while ((cal ? calActive : trackEnable) !== 1'b1) begin
         @(posedge core_clk);
         #1;
         n++;
         if (n > bound) begin
            mismatches++;
            print_verdict();
         end
      end
   endtask
   // Strobe rises during calibration and must not start a conversion
   task automatic s_powerup;
      int n;
      // Link reset needs serial edges while the core reset is held
      fork
         host.tick(4);
         repeat (15) @(negedge core_clk);
      join
      host.drive(1'b1);
      reset = 1'b0;
      waitSig(1'b0, 60, n);
      check(n, CAL);
      repeat (8) @(negedge core_clk);
      check(busyCycles, 0);
      host.drive(1'b0);
   endtask
   task automatic s_convert(input logic [RB-1:0] v, input int lag);
      logic [RB:0] w;
      int b;
      analogIn = v;
      b = busyCycles;
      host.sample(lag, w);
      check(w, {v, 1'b0});
      check(busyCycles - b, RB);
      check(trackEnable, 1'b1);
      check(resultValid, 1'b1);
      check($realtime - host.lastRise < 1000.0, 1'b1);
   endtask
   task automatic s_codes;
      logic [RB-1:0] codes [6] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff, 16'h0001, 16'ha5c3};
      for (int i = 0; i < 6; i++)
         s_convert(codes[i], (i % 2) * 20);
   endtask
   // Recalibration lands in mid-conversion
   task automatic s_recal;
      int n;
      host.drive(1'b1);
      repeat (6) @(negedge core_clk);
      recalRequest = 1'b1;
      waitSig(1'b1, 6, n);
      check(convBusy, 1'b0);
      check(resultValid, 1'b0);
      @(negedge core_clk);
      recalRequest = 1'b0;
      host.drive(1'b0);
      waitSig(1'b0, CAL + 10, n);
      s_convert(16'h3c5a, 0);
   endtask
   // Strobe kept high after the conversion: old word stays, new one waits in the FIFO
   task automatic s_waitlow;
      int n;
      logic [RB-1:0] w;
      analogIn = 16'h1234;
      host.drive(1'b1);
      repeat (RB + 6) @(negedge core_clk);
      check(trackEnable, 1'b0);
      check(convBusy, 1'b0);
      check(resultValid, 1'b1);
      host.drive(1'b0);
      waitSig(1'b0, 6, n);
      check(resultValid, 1'b1);
      repeat (4) @(negedge core_clk);
      for (int i = RB - 1; i >= 0; i--) begin
         w[i] = resultBit;
         host.tick(1);
      end
      check(w, 16'h1234);
   endtask
   initial begin
      s_powerup();
      s_codes();
      s_recal();
      s_waitlow();
      print_verdict();
   end
endmodule

// File: test/sradc_host_model.sv
// Host SPI master model: conversion strobe, serial clock, result capture.
// Assumes calls from the bench; the serial clock idles low between frames.
`timescale 1ns/1ps
module sradc_host_model #(
   parameter int RES_BITS = 16
) (
   input wire logic core_clk,
   output logic strobe,
   output logic serialClk,
   input wire logic resultBit
);
   realtime lastRise = -1000.0;
   initial begin
      strobe = 1'b0;
      serialClk = 1'b0;
   end
   // 15 ns period keeps the link under its ceiling
   task automatic tick(input int n);
      repeat (n) begin
         #7.5 serialClk = 1'b1;
         #7.5 serialClk = 1'b0;
      end
   endtask
   // Rises are spaced one sample period apart at least
   task automatic drive(input logic v);
      @(negedge core_clk);
      if (v && !strobe) begin
         while ($realtime - lastRise < 1000.0)
            @(negedge core_clk);
         lastRise = $realtime;
      end
      strobe = v;
   endtask
   // Lag makes a slow host; one extra clock shows the idle bit
   task automatic sample(input int lag, output logic [RES_BITS:0] word);
      drive(1'b1);
      repeat (RES_BITS + 6 + lag) @(negedge core_clk);
      strobe = 1'b0;
      repeat (5 + lag) @(negedge core_clk);
      word[RES_BITS] = resultBit;
      for (int i = RES_BITS - 1; i >= 0; i--) begin
         tick(1);
         word[i] = resultBit;
      end
   endtask
endmodule
